//--- src/dcc_pkg.sv
// shared constants for the dac and comparator control block
`default_nettype none

package dcc_pkg;
  // widths
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CODE_W = 5;
  localparam int unsigned TAP_W = 6;
  localparam int unsigned NUM_CMP = 2;
  // register offsets
  localparam logic [3:0] OFS_DAC_CTL0 = 4'h0;
  localparam logic [3:0] OFS_DAC_CTL1 = 4'h1;
  localparam logic [3:0] OFS_CMP1_CTL0 = 4'h2;
  localparam logic [3:0] OFS_CMP1_CTL1 = 4'h3;
  localparam logic [3:0] OFS_CMP_STRIDE = 4'h2;
  localparam logic [3:0] OFS_CMP_OUT = 4'h6;
  localparam logic [3:0] OFS_CMP_IRQ = 4'h7;
  localparam logic [3:0] OFS_PIN_CTL = 4'h8;
  localparam logic [3:0] OFS_PIN_READ = 4'h9;
  // dac_control_0 / dac_control_1 fields
  localparam int unsigned DAC0_EN_BIT = 7;
  localparam int unsigned DAC0_OE1_BIT = 5;
  localparam int unsigned DAC0_OE2_BIT = 4;
  localparam int unsigned DAC0_PSS_LSB = 2;
  localparam logic [7:0] DAC0_WMASK = 8'hBC;
  localparam logic [7:0] DAC1_WMASK = 8'h1F;
  localparam logic [7:0] DAC_RST = 8'h00;
  // cmp_control_0 fields
  localparam int unsigned CMP0_ON_BIT = 7;
  localparam int unsigned CMP0_OUT_BIT = 6;
  localparam int unsigned CMP0_OE_BIT = 5;
  localparam int unsigned CMP0_POL_BIT = 4;
  localparam int unsigned CMP0_SP_BIT = 2;
  localparam int unsigned CMP0_HYS_BIT = 1;
  localparam int unsigned CMP0_SYNC_BIT = 0;
  localparam logic [7:0] CMP0_WMASK = 8'hB7;
  localparam logic [7:0] CMP0_RST = 8'h04;
  // cmp_control_1 fields
  localparam int unsigned CMP1_INTP_BIT = 7;
  localparam int unsigned CMP1_INTN_BIT = 6;
  localparam int unsigned CMP1_PCH_LSB = 4;
  localparam int unsigned CMP1_NCH_LSB = 0;
  localparam logic [7:0] CMP1_WMASK = 8'hF7;
  localparam logic [7:0] CMP1_RST = 8'h00;
  // pin control fields
  localparam int unsigned PIN_DIR_LSB = 0;
  localparam int unsigned PIN_LAT_LSB = 2;
  localparam int unsigned PIN_LPS_BIT = 4;
  localparam logic [7:0] PIN_WMASK = 8'h1F;
  localparam logic [7:0] PIN_RST = 8'h03;
  // positive source codes
  localparam logic [1:0] PSS_SUPPLY = 2'h0;
  localparam logic [1:0] PSS_PIN = 2'h1;
  localparam logic [1:0] PSS_FIXED = 2'h2;
  // ladder ends
  localparam logic [CODE_W-1:0] CODE_ALL0 = 5'h00;
  localparam logic [CODE_W-1:0] CODE_ALL1 = 5'h1F;
  localparam logic [TAP_W-1:0] TAP_ZERO = 6'h00;
  localparam logic [TAP_W-1:0] TAP_FULL = 6'h20;
  // timing: instruction cycle from the system clock
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned INSTR_PERIOD_NS = 40;
  localparam int unsigned INSTR_DIV = INSTR_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
endpackage

`default_nettype wire

//--- src/dcc_cmp_if.sv
// carrier between the control top and one comparator unit
`default_nettype none

interface dcc_cmp_if;
  logic en;
  logic pol;
  logic oe;
  logic dir;
  logic port_lat;
  logic sync_en;
  logic intp;
  logic intn;
  logic tick;
  logic tmr_fall;
  logic status;
  logic pin_val;
  logic pin_oe;
  logic sync_out;
  logic rise_evt;
  logic fall_evt;
  modport ctl (output en, pol, oe, dir, port_lat, sync_en, intp, intn, tick, tmr_fall,
               input status, pin_val, pin_oe, sync_out, rise_evt, fall_evt);
  modport unit (input en, pol, oe, dir, port_lat, sync_en, intp, intn, tick, tmr_fall,
                output status, pin_val, pin_oe, sync_out, rise_evt, fall_evt);
endinterface

`default_nettype wire

//--- src/dcc_cmp_unit.sv
// one comparator: sync, polarity, per-cycle latch, edges, pin output
`default_nettype none

module dcc_cmp_unit import dcc_pkg::*; (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // raw analog decision, asynchronous
  input wire logic i_raw,
  // control and status
  dcc_cmp_if.unit cif
);
  logic raw_s1_ff;
  logic raw_s2_ff;
  logic status_ff;
  logic sync_lat_ff;
  logic pin_val_ff;
  logic pin_oe_ff;
  logic sync_out_ff;
  logic rise_ff;
  logic fall_ff;

  wire decision = cif.en & raw_s2_ff;
  wire pol_val = decision ^ cif.pol;
  wire rise = cif.tick & pol_val & ~status_ff;
  wire fall = cif.tick & ~pol_val & status_ff;
  // oe steers the data even while the comparator is off
  wire nxt_pin_val = cif.oe ? pol_val : cif.port_lat;
  wire nxt_pin_oe = ~cif.dir & (~cif.oe | cif.en);
  wire nxt_sync_lat = cif.tmr_fall ? status_ff : sync_lat_ff;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      raw_s1_ff <= 1'b0;
      raw_s2_ff <= 1'b0;
      status_ff <= 1'b0;
      sync_lat_ff <= 1'b0;
      pin_val_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      sync_out_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      raw_s1_ff <= i_raw;
      raw_s2_ff <= raw_s1_ff;
      if (cif.tick) begin
        status_ff <= pol_val;
      end
      sync_lat_ff <= nxt_sync_lat;
      pin_val_ff <= nxt_pin_val;
      pin_oe_ff <= nxt_pin_oe;
      sync_out_ff <= cif.sync_en ? sync_lat_ff : status_ff;
      rise_ff <= rise & cif.intp;
      fall_ff <= fall & cif.intn;
    end
  end

  assign cif.status = status_ff;
  assign cif.pin_val = pin_val_ff;
  assign cif.pin_oe = pin_oe_ff;
  assign cif.sync_out = sync_out_ff;
  assign cif.rise_evt = rise_ff;
  assign cif.fall_evt = fall_ff;
endmodule // dcc_cmp_unit

`default_nettype wire

//--- src/dcc_dac_tap.sv
// ladder tap and source selection for the 5-bit reference dac
`default_nettype none

module dcc_dac_tap import dcc_pkg::*; (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // settings
  input wire logic i_enable,
  input wire logic i_low_power_select,
  input wire logic [CODE_W-1:0] i_level_code,
  input wire logic [1:0] i_positive_source_field,
  // analog controls
  output logic [TAP_W-1:0] o_tap,
  output logic o_tap_valid,
  output logic o_ladder_en,
  output logic [2:0] o_src_sel
);
  wire dis_hi = ~i_enable & i_low_power_select & (i_level_code == CODE_ALL1);
  wire dis_lo = ~i_enable & ~i_low_power_select & (i_level_code == CODE_ALL0);
  // tap k of 32 gives span*k/32 above ground
  wire [TAP_W-1:0] nxt_tap = i_enable ? {1'b0, i_level_code} :
                             (dis_hi ? TAP_FULL : TAP_ZERO);
  wire [2:0] nxt_src = (i_positive_source_field == PSS_SUPPLY) ? 3'h1 :
                       (i_positive_source_field == PSS_PIN) ? 3'h2 :
                       (i_positive_source_field == PSS_FIXED) ? 3'h4 : 3'h0;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tap <= TAP_ZERO;
      o_tap_valid <= 1'b0;
      o_ladder_en <= 1'b0;
      o_src_sel <= 3'h0;
    end else begin
      o_tap <= nxt_tap;
      o_tap_valid <= i_enable | dis_hi | dis_lo;
      o_ladder_en <= i_enable;
      o_src_sel <= nxt_src;
    end
  end
endmodule // dcc_dac_tap

`default_nettype wire

//--- src/dcc_top.sv
// register file and control top of the dac and comparator block
//
// The register addresses and the address-and-strobe port were left to the implementer.
`default_nettype none

module dcc_top import dcc_pkg::*; (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // dac analog controls
  output logic [TAP_W-1:0] o_dac_tap,
  output logic o_dac_tap_valid,
  output logic o_dac_ladder_en,
  output logic [2:0] o_dac_src_sel,
  // dac output pins
  input wire logic [1:0] i_ref_pin_din,
  output logic [1:0] o_ref_out_pin_en,
  output logic [1:0] o_ref_pin_digital_off,
  // comparator analog side
  input wire logic [NUM_CMP-1:0] i_cmp_raw,
  output logic [NUM_CMP-1:0] o_cmp_enable,
  output logic [NUM_CMP-1:0] o_cmp_speed_power,
  output logic [NUM_CMP-1:0] o_cmp_hysteresis_enable,
  output logic [2*NUM_CMP-1:0] o_cmp_pos_chan,
  output logic [3*NUM_CMP-1:0] o_cmp_neg_chan,
  // comparator digital side
  input wire logic i_tmr_clk_src,
  output logic [NUM_CMP-1:0] o_cmp_pin_out,
  output logic [NUM_CMP-1:0] o_cmp_pin_oe,
  output logic [NUM_CMP-1:0] o_cmp_sync_out,
  output logic [NUM_CMP-1:0] o_cmp_irq_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [DATA_W-1:0] dac0_ff;
  logic [DATA_W-1:0] dac1_ff;
  logic [DATA_W-1:0] cmp0_ff [NUM_CMP];
  logic [DATA_W-1:0] cmp1_ff [NUM_CMP];
  logic [DATA_W-1:0] pin_ff;
  logic [NUM_CMP-1:0] irq_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0] div_ff;
  logic tick_ff;
  logic tmr_s1_ff;
  logic tmr_s2_ff;
  logic tmr_s3_ff;
  logic [1:0] refp_s1_ff;
  logic [1:0] refp_s2_ff;
  logic [1:0] ref_en_ff;
  logic [1:0] ref_off_ff;

  dcc_cmp_if cif [NUM_CMP] ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire hit_dac0 = (i_addr == OFS_DAC_CTL0);
  wire hit_dac1 = (i_addr == OFS_DAC_CTL1);
  wire hit_out = (i_addr == OFS_CMP_OUT);
  wire hit_irq = (i_addr == OFS_CMP_IRQ);
  wire hit_pin = (i_addr == OFS_PIN_CTL);
  wire hit_pread = (i_addr == OFS_PIN_READ);
  wire wr_dac0 = i_wr & hit_dac0;
  wire wr_dac1 = i_wr & hit_dac1;
  wire wr_irq = i_wr & hit_irq;
  wire wr_pin = i_wr & hit_pin;

  ////////////////////////////////////////////////////////////////////////////
  // dac control fields

  wire dac_en = dac0_ff[DAC0_EN_BIT];
  wire dac_oe1 = dac0_ff[DAC0_OE1_BIT];
  wire dac_oe2 = dac0_ff[DAC0_OE2_BIT];
  wire [1:0] dac_pss = dac0_ff[DAC0_PSS_LSB +: 2];
  wire [CODE_W-1:0] level_code = dac1_ff[CODE_W-1:0];
  wire low_power_select = pin_ff[PIN_LPS_BIT];
  wire [1:0] dac_pin_on = {dac_oe2, dac_oe1};
  // an assigned pin reads zero whatever sits on it
  wire [1:0] ref_pin_read = refp_s2_ff & ~dac_pin_on;

  wire [DATA_W-1:0] nxt_dac0 = (i_wdata & DAC0_WMASK);
  wire [DATA_W-1:0] nxt_dac1 = (i_wdata & DAC1_WMASK);
  wire [DATA_W-1:0] nxt_pin = (i_wdata & PIN_WMASK);

  ////////////////////////////////////////////////////////////////////////////
  // timer source: sync, then find the falling edge

  wire tmr_fall = tmr_s3_ff & ~tmr_s2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // comparators

  logic [NUM_CMP-1:0] status_vec;
  logic [NUM_CMP-1:0] set_vec;
  logic [NUM_CMP-1:0] hit_c0_vec;
  logic [NUM_CMP-1:0] hit_c1_vec;
  logic [DATA_W-1:0] c0_rd [NUM_CMP];
  logic [DATA_W-1:0] c1_rd [NUM_CMP];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      localparam logic [3:0] OFS_C0 = 4'(OFS_CMP1_CTL0 + OFS_CMP_STRIDE * gi);
      localparam logic [3:0] OFS_C1 = 4'(OFS_CMP1_CTL1 + OFS_CMP_STRIDE * gi);

      wire hit_c0 = (i_addr == OFS_C0);
      wire hit_c1 = (i_addr == OFS_C1);
      wire wr_c0 = i_wr & hit_c0;
      wire wr_c1 = i_wr & hit_c1;
      wire [DATA_W-1:0] nxt_c0 = (i_wdata & CMP0_WMASK);
      wire [DATA_W-1:0] nxt_c1 = (i_wdata & CMP1_WMASK);

      always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          cmp0_ff[gi] <= CMP0_RST;
          cmp1_ff[gi] <= CMP1_RST;
        end else begin
          if (wr_c0) begin
            cmp0_ff[gi] <= nxt_c0;
          end
          if (wr_c1) begin
            cmp1_ff[gi] <= nxt_c1;
          end
        end
      end

      assign cif[gi].en = cmp0_ff[gi][CMP0_ON_BIT];
      assign cif[gi].pol = cmp0_ff[gi][CMP0_POL_BIT];
      assign cif[gi].oe = cmp0_ff[gi][CMP0_OE_BIT];
      assign cif[gi].dir = pin_ff[PIN_DIR_LSB + gi];
      assign cif[gi].port_lat = pin_ff[PIN_LAT_LSB + gi];
      assign cif[gi].sync_en = cmp0_ff[gi][CMP0_SYNC_BIT];
      assign cif[gi].intp = cmp1_ff[gi][CMP1_INTP_BIT];
      assign cif[gi].intn = cmp1_ff[gi][CMP1_INTN_BIT];
      assign cif[gi].tick = tick_ff;
      assign cif[gi].tmr_fall = tmr_fall;

      dcc_cmp_unit u_cmp (
        .i_mclk (i_mclk),
        .i_arst_n (i_arst_n),
        .i_raw (i_cmp_raw[gi]),
        .cif (cif[gi])
      );

      assign status_vec[gi] = cif[gi].status;
      assign set_vec[gi] = cif[gi].rise_evt | cif[gi].fall_evt;
      assign hit_c0_vec[gi] = hit_c0;
      assign hit_c1_vec[gi] = hit_c1;
      // live status replaces the stored copy of bit 6
      assign c0_rd[gi] = cmp0_ff[gi] | (DATA_W'(cif[gi].status) << CMP0_OUT_BIT);
      assign c1_rd[gi] = cmp1_ff[gi];

      assign o_cmp_enable[gi] = cmp0_ff[gi][CMP0_ON_BIT];
      assign o_cmp_speed_power[gi] = cmp0_ff[gi][CMP0_SP_BIT];
      assign o_cmp_hysteresis_enable[gi] = cmp0_ff[gi][CMP0_HYS_BIT];
      assign o_cmp_pos_chan[2*gi +: 2] = cmp1_ff[gi][CMP1_PCH_LSB +: 2];
      assign o_cmp_neg_chan[3*gi +: 3] = cmp1_ff[gi][CMP1_NCH_LSB +: 3];
      assign o_cmp_pin_out[gi] = cif[gi].pin_val;
      assign o_cmp_pin_oe[gi] = cif[gi].pin_oe;
      assign o_cmp_sync_out[gi] = cif[gi].sync_out;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags: set beats a same-cycle clear

  wire [NUM_CMP-1:0] irq_clr = wr_irq ? i_wdata[NUM_CMP-1:0] : '0;
  wire [NUM_CMP-1:0] nxt_irq = (irq_ff & ~irq_clr) | set_vec;

  ////////////////////////////////////////////////////////////////////////////
  // read data

  wire [DATA_W-1:0] rd_c0 = hit_c0_vec[0] ? c0_rd[0] :
                            (hit_c0_vec[1] ? c0_rd[1] : '0);
  wire [DATA_W-1:0] rd_c1 = hit_c1_vec[0] ? c1_rd[0] :
                            (hit_c1_vec[1] ? c1_rd[1] : '0);
  wire [DATA_W-1:0] rd_out = DATA_W'(status_vec);
  wire [DATA_W-1:0] rd_irq = DATA_W'(irq_ff);
  wire [DATA_W-1:0] rd_pread = DATA_W'(ref_pin_read);
  // unmapped offsets answer zero
  wire [DATA_W-1:0] rd_mux = hit_dac0 ? dac0_ff :
                             hit_dac1 ? dac1_ff :
                             hit_out ? rd_out :
                             hit_irq ? rd_irq :
                             hit_pin ? pin_ff :
                             hit_pread ? rd_pread :
                             (rd_c0 | rd_c1);
  wire [DATA_W-1:0] nxt_rdata = i_rd ? rd_mux : '0;

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  // only the async reset touches these, so sleep and wake keep them

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dac0_ff <= DAC_RST;
      dac1_ff <= DAC_RST;
      pin_ff <= PIN_RST;
    end else begin
      if (wr_dac0) begin
        dac0_ff <= nxt_dac0;
      end
      if (wr_dac1) begin
        dac1_ff <= nxt_dac1;
      end
      if (wr_pin) begin
        pin_ff <= nxt_pin;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_ff <= '0;
      rdata_ff <= '0;
    end else begin
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction-cycle tick

  wire div_wrap = (div_ff == INSTR_LAST);
  wire [1:0] nxt_div = div_wrap ? 2'h0 : 2'(div_ff + 2'h1);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_ff <= 2'h0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= div_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tmr_s1_ff <= 1'b0;
      tmr_s2_ff <= 1'b0;
      tmr_s3_ff <= 1'b0;
      refp_s1_ff <= 2'h0;
      refp_s2_ff <= 2'h0;
    end else begin
      tmr_s1_ff <= i_tmr_clk_src;
      tmr_s2_ff <= tmr_s1_ff;
      tmr_s3_ff <= tmr_s2_ff;
      refp_s1_ff <= i_ref_pin_din;
      refp_s2_ff <= refp_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dac pin switches

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ref_en_ff <= 2'h0;
      ref_off_ff <= 2'h0;
    end else begin
      ref_en_ff <= dac_pin_on;
      ref_off_ff <= dac_pin_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dac ladder

  dcc_dac_tap u_dac (
    .i_mclk (i_mclk),
    .i_arst_n (i_arst_n),
    .i_enable (dac_en),
    .i_low_power_select (low_power_select),
    .i_level_code (level_code),
    .i_positive_source_field (dac_pss),
    .o_tap (o_dac_tap),
    .o_tap_valid (o_dac_tap_valid),
    .o_ladder_en (o_dac_ladder_en),
    .o_src_sel (o_dac_src_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_rdata = rdata_ff;
  assign o_ref_out_pin_en = ref_en_ff;
  assign o_ref_pin_digital_off = ref_off_ff;
  assign o_cmp_irq_flag = irq_ff;

endmodule // dcc_top

`default_nettype wire

//--- verif/dcc_top_monitor.sv
// assertion checker bound to the dac and comparator control top
`default_nettype none

module dcc_top_monitor import dcc_pkg::*; (
  // clock, reset and register port
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  // watched outputs
  input wire logic [TAP_W-1:0] o_dac_tap,
  input wire logic o_dac_tap_valid,
  input wire logic o_dac_ladder_en,
  input wire logic [2:0] o_dac_src_sel,
  input wire logic [1:0] o_ref_out_pin_en,
  input wire logic [1:0] o_ref_pin_digital_off,
  input wire logic [NUM_CMP-1:0] o_cmp_speed_power,
  input wire logic [NUM_CMP-1:0] o_cmp_irq_flag
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  wire logic wr_dac0 = i_wr && (i_addr == OFS_DAC_CTL0);
  wire logic clr0 = i_wr && (i_addr == OFS_CMP_IRQ) && i_wdata[0];
  wire logic [1:0] src_code = i_wdata[DAC0_PSS_LSB +: 2];
  // reserved source code selects nothing
  wire logic [2:0] sel_exp = (src_code == PSS_SUPPLY) ? 3'h1 :
                             (src_code == PSS_PIN) ? 3'h2 :
                             (src_code == PSS_FIXED) ? 3'h4 : 3'h0;

  //////////////////////////////////////////////////////////////////////
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  unmapped_rd_a: assert property (i_rd && i_addr >= 4'hA |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  ladder_en_a: assert property (wr_dac0 |-> ##2 o_dac_ladder_en == $past(i_wdata[7], 2))
    else $error("ladder enable does not follow enable bit");
  pin_en_a: assert property (wr_dac0 |-> ##2
      o_ref_out_pin_en == {$past(i_wdata[4], 2), $past(i_wdata[5], 2)})
    else $error("pin connect does not follow enable bits");
  src_sel_a: assert property (wr_dac0 |-> ##2 o_dac_src_sel == $past(sel_exp, 2))
    else $error("positive source select wrong");
  dig_off_a: assert property (o_ref_pin_digital_off == o_ref_out_pin_en)
    else $error("digital override differs from pin connect");
  tap_en_a: assert property (o_dac_ladder_en |-> o_dac_tap_valid)
    else $error("enabled dac output not tied to tap");
  tap_rail_a: assert property (o_dac_tap_valid && !o_dac_ladder_en |->
      o_dac_tap == TAP_ZERO || o_dac_tap == TAP_FULL)
    else $error("disabled dac tied to a mid tap");
  sp_reset_a: assert property ($rose(i_arst_n) |-> o_cmp_speed_power == 2'h3)
    else $error("speed bits not normal after reset");
  irq_clear_a: assert property ($fell(o_cmp_irq_flag[0]) |-> $past(clr0))
    else $error("interrupt flag dropped without clear");

  cover property (wr_dac0 && i_wdata[7]);
  cover property ($rose(o_cmp_irq_flag[0]));
  cover property (o_dac_tap_valid && !o_dac_ladder_en);
endmodule // dcc_top_monitor

bind dcc_top dcc_top_monitor u_dcc_top_monitor (.i_mclk, .i_arst_n, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_dac_tap, .o_dac_tap_valid, .o_dac_ladder_en, .o_dac_src_sel,
  .o_ref_out_pin_en, .o_ref_pin_digital_off, .o_cmp_speed_power, .o_cmp_irq_flag);

`default_nettype wire

//--- verif/dcc_top_bench.sv
// self-checking bench for the dac and comparator control top
`default_nettype none

module dcc_top_bench import dcc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, arst_n, wr, rd, tmr;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [5:0] tap;
  logic tap_valid, ladder_en;
  logic [2:0] src_sel;
  logic [1:0] din, pin_en, dig_off, raw, cmp_en, sp, hys, cpin, cpin_oe, irq, sync_out;
  logic [3:0] pchan;
  logic [5:0] nchan;
  int err_count, checks_done;
  // offset, write data, reset value
  logic [19:0] rows [9] = '{20'h0FF00, 20'h1FF00, 20'h2A704, 20'h3FF00, 20'h4A704,
                            20'h55A00, 20'h8FF03, 20'hAFF00, 20'hFFF00};

  dcc_top u_dcc_top (.i_mclk(mclk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_dac_tap(tap), .o_dac_tap_valid(tap_valid),
    .o_dac_ladder_en(ladder_en), .o_dac_src_sel(src_sel), .i_ref_pin_din(din),
    .o_ref_out_pin_en(pin_en), .o_ref_pin_digital_off(dig_off), .i_cmp_raw(raw),
    .o_cmp_enable(cmp_en), .o_cmp_speed_power(sp), .o_cmp_hysteresis_enable(hys),
    .o_cmp_pos_chan(pchan), .o_cmp_neg_chan(nchan), .i_tmr_clk_src(tmr), .o_cmp_pin_out(cpin),
    .o_cmp_pin_oe(cpin_oe), .o_cmp_sync_out(sync_out), .o_cmp_irq_flag(irq));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  function automatic logic [7:0] wmask(input logic [3:0] a);
    case (a)
      OFS_DAC_CTL0: return DAC0_WMASK;
      OFS_DAC_CTL1: return DAC1_WMASK;
      4'h2, 4'h4: return CMP0_WMASK;
      4'h3, 4'h5: return CMP1_WMASK;
      OFS_PIN_CTL: return PIN_WMASK;
      default: return 8'h00;
    endcase
  endfunction

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // whole run is under a thousand cycles, so ten times that is a hang
  initial begin
    #100000;
    err_count++;
    conclude();
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    din = 2'h3;
    raw = 2'h0;
    tmr = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      rd_reg(rows[i][19:16], rows[i][7:0]);
      wr_reg(rows[i][19:16], rows[i][15:8]);
      rd_reg(rows[i][19:16], rows[i][15:8] & wmask(rows[i][19:16]));
    end
    // channel fields left by the rows: cmp1 ctl1 F7, cmp2 ctl1 52
    chk("pos_chan", 8'h07, {4'h0, pchan});
    chk("neg_chan", 8'h17, {2'h0, nchan});
    $display("test registers done");
    wr_reg(OFS_PIN_CTL, 8'h03);
    wr_reg(OFS_DAC_CTL1, 8'h13);
    wr_reg(OFS_DAC_CTL0, 8'h80);
    settle(3);
    chk("tap", 8'h13, {2'h0, tap});
    chk("tap_valid", 8'h01, {7'h0, tap_valid});
    for (int p = 0; p < 4; p++) begin
      wr_reg(OFS_DAC_CTL0, 8'h80 | (8'(p) << 2));
      settle(3);
      chk("src_sel", (p == 3) ? 8'h00 : 8'(1 << p), {5'h0, src_sel});
    end
    // disabled dac: rails only for the two end codes
    wr_reg(OFS_DAC_CTL0, 8'h00);
    wr_reg(OFS_PIN_CTL, 8'h13);
    wr_reg(OFS_DAC_CTL1, 8'h1F);
    settle(3);
    chk("ladder_en", 8'h00, {7'h0, ladder_en});
    chk("rail_tap", {2'h0, TAP_FULL}, {2'h0, tap});
    chk("rail_valid", 8'h01, {7'h0, tap_valid});
    wr_reg(OFS_PIN_CTL, 8'h03);
    wr_reg(OFS_DAC_CTL1, 8'h00);
    settle(3);
    chk("gnd_tap", 8'h00, {2'h0, tap});
    chk("gnd_valid", 8'h01, {7'h0, tap_valid});
    wr_reg(OFS_DAC_CTL1, 8'h05);
    settle(3);
    chk("float_valid", 8'h00, {7'h0, tap_valid});
    for (int k = 0; k < 2; k++) begin
      wr_reg(OFS_DAC_CTL0, (k == 1) ? 8'h10 : 8'h20);
      settle(4);
      chk("pin_en", 8'(k + 1), {6'h0, pin_en});
      chk("digital_off", 8'(k + 1), {6'h0, dig_off});
      rd_reg(OFS_PIN_READ, (k == 1) ? 8'h01 : 8'h02);
    end
    $display("test dac done");
    wr_reg(OFS_PIN_CTL, 8'h00);
    wr_reg(OFS_CMP1_CTL1, 8'h80);
    wr_reg(OFS_CMP_IRQ, 8'h03);
    for (int t = 0; t < 4; t++) begin
      @(posedge mclk) raw <= 2'(t & 1);
      wr_reg(OFS_CMP1_CTL0, 8'hA4 | (8'(t & 2) << 3));
      settle(10);
      rd_reg(OFS_CMP_OUT, 8'((t & 1) ^ (t >> 1)));
      rd_reg(OFS_CMP1_CTL0, 8'hA4 | (8'(t & 2) << 3) | (8'((t & 1) ^ (t >> 1)) << 6));
      chk("pin_out", 8'((t & 1) ^ (t >> 1)), {7'h0, cpin[0]});
      chk("pin_oe", 8'h01, {7'h0, cpin_oe[0]});
    end
    chk("rise_flag", 8'h01, {7'h0, irq[0]});
    wr_reg(OFS_CMP_IRQ, 8'h01);
    settle(2);
    chk("flag_clear", 8'h00, {7'h0, irq[0]});
    wr_reg(OFS_CMP1_CTL1, 8'h40);
    wr_reg(OFS_CMP1_CTL0, 8'hA4);
    settle(10);
    chk("rise_masked", 8'h00, {7'h0, irq[0]});
    @(posedge mclk) raw <= 2'h0;
    settle(10);
    chk("fall_flag", 8'h01, {7'h0, irq[0]});
    wr_reg(OFS_CMP1_CTL0, 8'h24);
    settle(3);
    chk("oe_off_pin", 8'h00, {7'h0, cpin_oe[0]});
    wr_reg(OFS_PIN_CTL, 8'h04);
    wr_reg(OFS_CMP1_CTL0, 8'h86);
    settle(3);
    chk("latch_oe", 8'h01, {7'h0, cpin_oe[0]});
    chk("latch_pin", 8'h01, {7'h0, cpin[0]});
    chk("hys", 8'h01, {7'h0, hys[0]});
    chk("cmp_en", 8'h01, {7'h0, cmp_en[0]});
    wr_reg(OFS_PIN_CTL, 8'h05);
    wr_reg(OFS_CMP1_CTL0, 8'hA2);
    settle(3);
    chk("dir_in_oe", 8'h00, {7'h0, cpin_oe[0]});
    chk("low_power", 8'h00, {7'h0, sp[0]});
    // sync mode: output holds until the timer source falls
    @(posedge mclk) raw <= 2'h1;
    wr_reg(OFS_CMP1_CTL0, 8'h81);
    settle(10);
    chk("sync_hold", 8'h00, {6'h0, sync_out});
    @(posedge mclk) tmr <= 1'b1;
    settle(6);
    chk("sync_rise", 8'h00, {6'h0, sync_out});
    @(posedge mclk) tmr <= 1'b0;
    settle(6);
    chk("sync_fall", 8'h01, {6'h0, sync_out});
    @(posedge mclk) raw <= 2'h0;
    settle(10);
    chk("sync_kept", 8'h01, {6'h0, sync_out});
    wr_reg(OFS_CMP1_CTL0, 8'h80);
    settle(3);
    chk("sync_off", 8'h00, {6'h0, sync_out});
    chk("cmp2_pin_oe", 8'h02, {6'h0, cpin_oe});
    $display("test comparator done");
    wr_reg(OFS_DAC_CTL1, 8'h0A);
    wr_reg(OFS_DAC_CTL0, 8'hB0);
    settle(2);
    // reset must undo a live setting, not one that never landed
    chk("pre_ladder", 8'h01, {7'h0, ladder_en});
    chk("pre_pins", 8'h03, {6'h0, pin_en});
    chk("pre_tap", 8'h0A, {2'h0, tap});
    @(posedge mclk) arst_n <= 1'b0;
    settle(2);
    @(posedge mclk) arst_n <= 1'b1;
    settle(1);
    chk("rst_ladder", 8'h00, {7'h0, ladder_en});
    chk("rst_pins", 8'h00, {6'h0, pin_en});
    chk("rst_speed", 8'h03, {6'h0, sp});
    rd_reg(OFS_DAC_CTL1, 8'h00);
    rd_reg(OFS_DAC_CTL0, 8'h00);
    $display("test reset done");
    conclude();
  end
endmodule // dcc_top_bench

`default_nettype wire
